// file: adchc_asserts.sv
// checker watching the pins between the converter end and the host end
`timescale 1ns/10ps
`default_nettype none
module adchc_asserts #(
  parameter logic [7:0] CONV_CYC = 8'h28
) (
  input wire logic mclk_in, // clock
  input wire logic srst_in, // sync reset
  input wire logic iface_type_sel, // 0 parallel, 1 serial
  input wire logic word_byte_sel, // 1 byte mode
  input wire logic ctrl_source_sel, // 1 software
  input wire logic seq_mode_bit, // sequential
  input wire logic standby_n, // low powers down
  input wire logic conv_start_pair_b, // pair b start
  input wire logic conv_start_pair_c, // pair c start
  input wire logic frame_sync_n, // chip select or frame sync
  input wire logic read_n, // read strobe
  input wire logic [15:0] dev_db, // device bus data
  input wire logic dev_db_oe_n, // device drives bus
  input wire logic [15:0] db_wire, // resolved bus
  input wire logic busy_int // busy
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  // ==========================================================
  // busy length counter
  logic [7:0] busy_len_ff;
  always_ff @(posedge mclk_in)
    busy_len_ff <= (srst_in || !busy_int) ? 8'h00 : busy_len_ff + 8'h01;
  // ==========================================================
  // assertions
  a_par_only:
    assert property (!dev_db_oe_n |-> !iface_type_sel)
    else $error("bus driven in serial mode");
  a_db_after_read:
    assert property (!dev_db_oe_n |-> $past(read_n) == 1'b0
      && $past(frame_sync_n) == 1'b0)
    else $error("bus driven without select and read");
  a_read_drives:
    assert property ($fell(read_n) && !frame_sync_n && !iface_type_sel
      |=> !dev_db_oe_n)
    else $error("read low did not drive bus");
  a_cs_with_rd:
    assert property (!iface_type_sel && !read_n |-> !frame_sync_n)
    else $error("read without chip select");
  a_byte_upper:
    assert property (!dev_db_oe_n && word_byte_sel |-> dev_db[7:0] == 8'h00)
    else $error("byte mode used low lines");
  a_ser_rd_low:
    assert property (iface_type_sel [*3] |-> !read_n && db_wire[0])
    else $error("serial mode without read low and lane select");
  a_seq_pulse:
    assert property ($rose(busy_int) && seq_mode_bit |=> !busy_int)
    else $error("sequential busy longer than one cycle");
  a_busy_span:
    assert property ($fell(busy_int) && !seq_mode_bit
      |-> busy_len_ff == CONV_CYC)
    else $error("busy length wrong");
  a_standby_n_quiet:
    assert property (!standby_n [*2] |-> !busy_int && dev_db_oe_n)
    else $error("activity in standby");
  a_sw_bc_held:
    assert property (ctrl_source_sel && !seq_mode_bit
      |-> !conv_start_pair_b && !conv_start_pair_c)
    else $error("pair b or c toggled outside sequential mode");
endmodule : adchc_asserts
`default_nettype wire

// file: adchc_bench.sv
// self-checking bench: host end and converter end joined by the pin bundle
`timescale 1ns/10ps
`default_nettype none
module adchc_bench;
  import adchc_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic start_in = 1'b0;
  logic read_in = 1'b0;
  logic [2:0] pairs_in = 3'h0;
  // standby_n, iface, word_byte, hb_first, ctrl_src, seq
  logic [5:0] cfg = 6'h20;
  adchc_res_t sample_in = '0;
  logic ready_out;
  logic data_valid_out;
  logic [15:0] data_out;
  logic [2:0] converting_out;
  logic [2:0] read_ptr_out;
  int seed = 32'h66e8_973a;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  adchc_if bus ();
  adchc_host u_adchc_host (.mclk_in(mclk_in), .srst_in(srst_in),
    .pins(bus.host), .start_in(start_in), .pairs_in(pairs_in),
    .read_in(read_in), .iface_type_in(cfg[4]), .word_byte_in(cfg[3]),
    .hb_first_in(cfg[2]), .ctrl_source_in(cfg[1]), .seq_mode_in(cfg[0]),
    .standby_n_in(cfg[5]), .ready_out(ready_out), .data_out(data_out),
    .data_valid_out(data_valid_out));
  adchc_dev #(.CONV_CYC(8'h04)) u_adchc_dev (.mclk_in(mclk_in),
    .srst_in(srst_in), .pins(bus.dev), .sample_in(sample_in),
    .converting_out(converting_out), .read_ptr_out(read_ptr_out));
  adchc_asserts #(.CONV_CYC(8'h04)) u_adchc_asserts (.mclk_in(mclk_in),
    .srst_in(srst_in), .iface_type_sel(bus.iface_type_sel),
    .word_byte_sel(bus.word_byte_sel),
    .ctrl_source_sel(bus.ctrl_source_sel),
    .seq_mode_bit(bus.seq_mode_bit), .standby_n(bus.standby_n),
    .conv_start_pair_b(bus.conv_start_pair_b),
    .conv_start_pair_c(bus.conv_start_pair_c),
    .frame_sync_n(bus.frame_sync_n), .read_n(bus.read_n),
    .dev_db(bus.dev_db), .dev_db_oe_n(bus.dev_db_oe_n),
    .db_wire(bus.db_wire), .busy_int(bus.busy_int));
  // ==========================================================
  // clock and hang guard
  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // config pins lag the inputs a cycle, so settle before any request
  task automatic cfg_set(input logic [5:0] v);
    @(posedge mclk_in);
    cfg <= v;
    repeat (3) @(negedge mclk_in);
  endtask : cfg_set
  // pairs expected under conversion for a start on pins p
  function automatic logic [2:0] exp_pairs(input logic [5:0] c,
    input logic [2:0] p);
    if (!c[5])
      return 3'h0;
    if (c[1] && !c[0])
      return p[0] ? 3'h7 : 3'h0;
    return p;
  endfunction : exp_pairs
  task automatic conv(input logic [2:0] p);
    int i;
    for (i = 0; i < 60 && ready_out !== 1'b1; i++) @(negedge mclk_in);
    @(posedge mclk_in);
    start_in <= 1'b1;
    pairs_in <= p;
    @(posedge mclk_in);
    start_in <= 1'b0;
    for (i = 0; i < 20 && converting_out === 3'h0; i++) @(negedge mclk_in);
    check({13'h0000, converting_out}, {13'h0000, exp_pairs(cfg, p)});
    for (i = 0; i < 60 && converting_out !== 3'h0; i++) @(negedge mclk_in);
  endtask : conv
  task automatic rd(input logic [15:0] exp);
    int i;
    for (i = 0; i < 60 && ready_out !== 1'b1; i++) @(negedge mclk_in);
    @(posedge mclk_in);
    read_in <= 1'b1;
    @(posedge mclk_in);
    read_in <= 1'b0;
    for (i = 0; i < 40 && data_valid_out !== 1'b1; i++) @(negedge mclk_in);
    check(data_out, exp);
  endtask : rd
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    // parallel word, serial, byte low first, byte high first
    for (int t = 0; t < 4; t++)
    begin
      case (t)
        0: cfg_set(6'h20);
        1: cfg_set(6'h30);
        default: cfg_set({3'h5, t[0], 2'h0});
      endcase
      @(posedge mclk_in);
      // one hand-picked word per test: both end bits set
      for (int k = 0; k < 6; k++)
        sample_in[k] <= (k == t) ? 16'h8001 : 16'($random(seed));
      conv(3'h7);
      for (int k = 0; k < 6; k++)
      begin
        rd(sample_in[k]);
        if (k == 2)
        begin
          // pointer must have moved past the three words read
          repeat (2) @(negedge mclk_in);
          check({13'h0000, read_ptr_out}, 16'h0003);
        end
      end
      $display("readout test %0d done", t);
    end
    cfg_set(6'h23);
    conv(3'h2);
    conv(3'h4);
    conv(3'h1);
    $display("sequential test done");
    cfg_set(6'h22);
    conv(3'h1);
    $display("software test done");
    cfg_set(6'h00);
    conv(3'h7);
    cfg_set(6'h20);
    conv(3'h4);
    $display("standby test done");
    end_sim();
  end
endmodule : adchc_bench
`default_nettype wire

// file: adchc_defines.svh
// timing counts and field positions shared by both ends of the link
`ifndef ADCHC_DEFINES_SVH
`define ADCHC_DEFINES_SVH
`define ADCHC_WORD_W 16
`define ADCHC_BYTE_HI 15
`define ADCHC_BYTE_LO 8
`define ADCHC_NUM_CH 6
`define ADCHC_LAST_CH 3'h5
`define ADCHC_CONV_CYC 8'h28
`define ADCHC_START_HI 4'h2
`define ADCHC_RD_LOW 4'h2
`define ADCHC_FRAME_BITS 5'h10
`endif

// file: adchc_dev.sv
// converter end: conversion start, busy, parallel and serial readout
`timescale 1ns/10ps
`default_nettype none
`include "adchc_defines.svh"
module adchc_dev #(
  parameter logic [7:0] CONV_CYC = `ADCHC_CONV_CYC
) (
  input wire logic mclk_in, // 40 MHz, also the conversion clock
  input wire logic srst_in, // sync reset, active high
  adchc_if.dev pins, // converter pins
  input wire adchc_pkg::adchc_res_t sample_in, // a0,a1,b0,b1,c0,c1
  output logic [2:0] converting_out, // pairs under conversion
  output logic [2:0] read_ptr_out // next channel to be read
);
  import adchc_pkg::*;
  adchc_dev_s_t r_ff;
  adchc_dev_s_t nxt_r;
  logic [2:0] start_now;
  logic [2:0] rise;
  logic [2:0] trig;
  logic [15:0] word;
  logic par;
  logic rd_act;

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.busy = 1'b0;
    start_now = {pins.conv_start_pair_c, pins.conv_start_pair_b,
      pins.conv_start_pair_a};
    rise = start_now & ~r_ff.start_prev;
    nxt_r.start_prev = start_now;
    nxt_r.rd_prev = pins.read_n;
    nxt_r.fs_prev = pins.frame_sync_n;
    word = r_ff.res[r_ff.ptr];
    par = !pins.iface_type_sel;
    // ====================================================
    // conversion start decode
    if (!pins.ctrl_source_sel)
    begin
      trig = rise;
    end
    else if (pins.seq_mode_bit)
    begin
      trig = rise;
    end
    else
    begin
      // b and c carry no meaning here
      trig = rise[0] ? 3'h7 : 3'h0;
    end
    case (r_ff.st)
      ADCHC_D_IDLE:
      begin
        if (trig != 3'h0)
        begin
          nxt_r.st = ADCHC_D_CONV;
          nxt_r.pairs = trig;
          nxt_r.cnt = CONV_CYC - 8'h01;
          nxt_r.busy = !pins.seq_mode_bit;
        end
      end
      ADCHC_D_CONV:
      begin
        if (r_ff.cnt == 8'h00)
        begin
          for (int p = 0; p < 3; p++)
          begin
            if (r_ff.pairs[p])
            begin
              nxt_r.res[2 * p] = sample_in[2 * p];
              nxt_r.res[2 * p + 1] = sample_in[2 * p + 1];
            end
          end
          nxt_r.ptr = 3'h0;
          nxt_r.phase = 1'b0;
          nxt_r.pairs = 3'h0;
          nxt_r.st = ADCHC_D_IDLE;
          nxt_r.busy = pins.seq_mode_bit;
        end
        else
        begin
          nxt_r.cnt = r_ff.cnt - 8'h01;
          nxt_r.busy = !pins.seq_mode_bit;
        end
      end
      default:
      begin
        nxt_r.st = ADCHC_D_IDLE;
      end
    endcase
    // ====================================================
    // parallel readout
    rd_act = par && !pins.frame_sync_n && !pins.read_n;
    nxt_r.db_oe_n = !rd_act;
    if (!pins.word_byte_sel)
    begin
      nxt_r.db = word;
    end
    else
    begin
      nxt_r.db = {(r_ff.phase ^ !pins.high_byte_first) ? word[7:0] :
        word[15:8], 8'h00};
    end
    // host lifts select together with read: use last cycle's select
    if (par && !r_ff.fs_prev && pins.read_n && !r_ff.rd_prev)
    begin
      if (pins.word_byte_sel && !r_ff.phase)
      begin
        nxt_r.phase = 1'b1;
      end
      else
      begin
        nxt_r.phase = 1'b0;
        nxt_r.ptr = (r_ff.ptr == `ADCHC_LAST_CH) ? 3'h0 :
          r_ff.ptr + 3'h1;
      end
    end
    // ====================================================
    // serial readout, one bit per clock on lane a
    if (!par && !pins.db_wire[0])
    begin
      // lane disabled: stays low, frame ignored
      nxt_r.sdo = 1'b0;
      nxt_r.bits = 5'h00;
    end
    else if (!par && r_ff.fs_prev && !pins.frame_sync_n)
    begin
      nxt_r.shreg = word;
      nxt_r.sdo = word[15];
      nxt_r.bits = `ADCHC_FRAME_BITS - 5'h01;
      nxt_r.ptr = (r_ff.ptr == `ADCHC_LAST_CH) ? 3'h0 : r_ff.ptr + 3'h1;
    end
    else if (r_ff.bits != 5'h00)
    begin
      nxt_r.shreg = {r_ff.shreg[14:0], 1'b0};
      nxt_r.sdo = r_ff.shreg[14];
      nxt_r.bits = r_ff.bits - 5'h01;
    end
    // ====================================================
    // standby: everything idle, conversions dropped
    if (!pins.standby_n)
    begin
      nxt_r.st = ADCHC_D_IDLE;
      nxt_r.pairs = 3'h0;
      nxt_r.busy = 1'b0;
      nxt_r.db_oe_n = 1'b1;
      nxt_r.sdo = 1'b0;
      nxt_r.bits = 5'h00;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      r_ff <= '{st: ADCHC_D_IDLE, rd_prev: 1'b1, fs_prev: 1'b1,
        db_oe_n: 1'b1, default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign pins.dev_db = r_ff.db;
  assign pins.dev_db_oe_n = r_ff.db_oe_n;
  assign pins.busy_int = r_ff.busy;
  assign pins.serial_out_lane_a = r_ff.sdo;
  assign converting_out = r_ff.pairs;
  assign read_ptr_out = r_ff.ptr;
endmodule : adchc_dev
`default_nettype wire

// file: adchc_host.sv
// host end: starts conversions and reads results over parallel or serial
`timescale 1ns/10ps
`default_nettype none
`include "adchc_defines.svh"
module adchc_host #(
  parameter logic [3:0] START_HI = `ADCHC_START_HI,
  parameter logic [3:0] RD_LOW = `ADCHC_RD_LOW
) (
  input wire logic mclk_in, // 40 MHz clock
  input wire logic srst_in, // sync reset, active high
  adchc_if.host pins, // converter pins
  input wire logic start_in, // pulse: start conversion
  input wire logic [2:0] pairs_in, // pairs to start, bit0 = pair a
  input wire logic read_in, // pulse: read one result
  input wire logic iface_type_in, // 0 parallel, 1 serial
  input wire logic word_byte_in, // 0 word, 1 byte
  input wire logic hb_first_in, // byte mode: high byte first
  input wire logic ctrl_source_in, // 0 hardware, 1 software
  input wire logic seq_mode_in, // sequential mode configured
  input wire logic standby_n_in, // low powers the converter down
  output logic ready_out, // idle, may take a request
  output logic [15:0] data_out, // last result read
  output logic data_valid_out // pulse: data_out updated
);
  import adchc_pkg::*;
  adchc_host_s_t r_ff;
  adchc_host_s_t nxt_r;

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.valid = 1'b0;
    nxt_r.iface = iface_type_in;
    nxt_r.word_byte = word_byte_in;
    nxt_r.hb_first = hb_first_in;
    nxt_r.ctrl_src = ctrl_source_in;
    nxt_r.seq = seq_mode_in;
    nxt_r.standby_n = standby_n_in;
    // serial: lane a select held high, read tied low; these follow the
    // select pin in the same cycle so read never looks active in parallel
    nxt_r.lsb = nxt_r.iface;
    nxt_r.lsb_oe_n = !nxt_r.iface;
    if (nxt_r.iface)
    begin
      nxt_r.read_n = 1'b0;
    end
    case (r_ff.st)
      ADCHC_H_IDLE:
      begin
        if (!nxt_r.iface)
        begin
          nxt_r.read_n = 1'b1;
        end
        nxt_r.cs_fs_n = 1'b1;
        if (start_in)
        begin
          nxt_r.st = ADCHC_H_START;
          nxt_r.cnt = {1'b0, START_HI - 4'h1};
          if (r_ff.ctrl_src && !r_ff.seq)
          begin
            nxt_r.starts = 3'h1;
          end
          else
          begin
            nxt_r.starts = pairs_in;
          end
        end
        else if (read_in && r_ff.iface)
        begin
          nxt_r.st = ADCHC_H_FRAME;
          nxt_r.cs_fs_n = 1'b0;
          nxt_r.cnt = 5'h00;
        end
        else if (read_in)
        begin
          nxt_r.st = ADCHC_H_RLOW;
          nxt_r.cs_fs_n = 1'b0;
          nxt_r.read_n = 1'b0;
          nxt_r.phase = 1'b0;
          nxt_r.cnt = {1'b0, RD_LOW - 4'h1};
        end
      end
      ADCHC_H_START:
      begin
        if (r_ff.cnt == 5'h00)
        begin
          nxt_r.starts = 3'h0;
          nxt_r.st = ADCHC_H_IDLE;
        end
        else
        begin
          nxt_r.cnt = r_ff.cnt - 5'h01;
        end
      end
      ADCHC_H_RLOW:
      begin
        if (r_ff.cnt != 5'h00)
        begin
          nxt_r.cnt = r_ff.cnt - 5'h01;
        end
        else
        begin
          nxt_r.read_n = 1'b1;
          if (r_ff.word_byte && !r_ff.phase)
          begin
            // first of two byte accesses on the upper lines
            nxt_r.first = pins.db_wire[`ADCHC_BYTE_HI:`ADCHC_BYTE_LO];
            nxt_r.phase = 1'b1;
            nxt_r.st = ADCHC_H_RGAP;
          end
          else
          begin
            if (!r_ff.word_byte)
            begin
              nxt_r.data = pins.db_wire;
            end
            else if (r_ff.hb_first)
            begin
              nxt_r.data = {r_ff.first,
                pins.db_wire[`ADCHC_BYTE_HI:`ADCHC_BYTE_LO]};
            end
            else
            begin
              nxt_r.data = {pins.db_wire[`ADCHC_BYTE_HI:`ADCHC_BYTE_LO],
                r_ff.first};
            end
            nxt_r.valid = 1'b1;
            nxt_r.cs_fs_n = 1'b1;
            nxt_r.st = ADCHC_H_IDLE;
          end
        end
      end
      ADCHC_H_RGAP:
      begin
        nxt_r.read_n = 1'b0;
        nxt_r.cnt = {1'b0, RD_LOW - 4'h1};
        nxt_r.st = ADCHC_H_RLOW;
      end
      ADCHC_H_FRAME:
      begin
        // first edge after the fall is the device's load cycle
        nxt_r.cnt = r_ff.cnt + 5'h01;
        if (r_ff.cnt != 5'h00)
        begin
          nxt_r.shin = {r_ff.shin[14:0], pins.serial_out_lane_a};
        end
        if (r_ff.cnt == `ADCHC_FRAME_BITS)
        begin
          nxt_r.data = {r_ff.shin[14:0], pins.serial_out_lane_a};
          nxt_r.valid = 1'b1;
          nxt_r.cs_fs_n = 1'b1;
          nxt_r.st = ADCHC_H_IDLE;
        end
      end
      default:
      begin
        nxt_r.st = ADCHC_H_IDLE;
      end
    endcase
    nxt_r.ready = (nxt_r.st == ADCHC_H_IDLE);
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      r_ff <= '{st: ADCHC_H_IDLE, cs_fs_n: 1'b1, read_n: 1'b1,
        lsb_oe_n: 1'b1, ready: 1'b1, default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign pins.iface_type_sel = r_ff.iface;
  assign pins.word_byte_sel = r_ff.word_byte;
  assign pins.high_byte_first = r_ff.hb_first;
  assign pins.ctrl_source_sel = r_ff.ctrl_src;
  assign pins.seq_mode_bit = r_ff.seq;
  assign pins.standby_n = r_ff.standby_n;
  assign pins.conv_start_pair_a = r_ff.starts[0];
  assign pins.conv_start_pair_b = r_ff.starts[1];
  assign pins.conv_start_pair_c = r_ff.starts[2];
  assign pins.frame_sync_n = r_ff.cs_fs_n;
  assign pins.read_n = r_ff.read_n;
  assign pins.data_line_lsb = r_ff.lsb;
  assign pins.data_line_lsb_oe_n = r_ff.lsb_oe_n;
  assign ready_out = r_ff.ready;
  assign data_out = r_ff.data;
  assign data_valid_out = r_ff.valid;
endmodule : adchc_host
`default_nettype wire

// file: adchc_if.sv
// pin bundle between converter control logic and its host
`timescale 1ns/10ps
`default_nettype none
interface adchc_if;
  logic iface_type_sel;
  logic word_byte_sel;
  logic high_byte_first;
  logic ctrl_source_sel;
  logic seq_mode_bit;
  logic standby_n;
  logic conv_start_pair_a;
  logic conv_start_pair_b;
  logic conv_start_pair_c;
  logic frame_sync_n;
  logic read_n;
  logic [15:0] dev_db;
  logic dev_db_oe_n;
  logic data_line_lsb;
  logic data_line_lsb_oe_n;
  logic [15:0] db_wire;
  logic busy_int;
  logic serial_out_lane_a;
  // bus level resolved from the two enables; undriven lines read low
  assign db_wire = !dev_db_oe_n ? dev_db :
    {15'h0000, !data_line_lsb_oe_n & data_line_lsb};
  modport dev (input iface_type_sel, word_byte_sel, high_byte_first,
    ctrl_source_sel, seq_mode_bit, standby_n, conv_start_pair_a,
    conv_start_pair_b, conv_start_pair_c, frame_sync_n, read_n, db_wire,
    output dev_db, dev_db_oe_n, busy_int, serial_out_lane_a);
  modport host (output iface_type_sel, word_byte_sel, high_byte_first,
    ctrl_source_sel, seq_mode_bit, standby_n, conv_start_pair_a,
    conv_start_pair_b, conv_start_pair_c, frame_sync_n, read_n,
    data_line_lsb, data_line_lsb_oe_n,
    input db_wire, busy_int, serial_out_lane_a);
endinterface : adchc_if
`default_nettype wire

// file: adchc_pkg.sv
// types shared by both ends of the converter control link
package adchc_pkg;
  typedef logic [5:0][15:0] adchc_res_t;
  typedef enum {ADCHC_D_IDLE, ADCHC_D_CONV} adchc_dev_st_t;
  typedef enum {ADCHC_H_IDLE, ADCHC_H_START, ADCHC_H_RLOW, ADCHC_H_RGAP,
    ADCHC_H_FRAME} adchc_host_st_t;
  typedef struct packed {
    adchc_dev_st_t st;
    logic [7:0] cnt;
    logic [2:0] pairs;
    logic [2:0] start_prev;
    logic rd_prev;
    logic fs_prev;
    logic [2:0] ptr;
    logic phase;
    adchc_res_t res;
    logic [15:0] shreg;
    logic [4:0] bits;
    logic busy;
    logic [15:0] db;
    logic db_oe_n;
    logic sdo;
  } adchc_dev_s_t;
  typedef struct packed {
    adchc_host_st_t st;
    logic [4:0] cnt;
    logic phase;
    logic [7:0] first;
    logic [15:0] shin;
    logic iface;
    logic word_byte;
    logic hb_first;
    logic ctrl_src;
    logic seq;
    logic standby_n;
    logic [2:0] starts;
    logic cs_fs_n;
    logic read_n;
    logic lsb;
    logic lsb_oe_n;
    logic [15:0] data;
    logic valid;
    logic ready;
  } adchc_host_s_t;
endpackage : adchc_pkg
